// [rtl/ee_spi_core.sv]
// Purpose: Serial EEPROM core: command decode, write protection, page
//          load, self-timed programming, sequential and status reads.
// Assumes: sck comes from the host; mclk runs free; cs_n stays high
//          for at least 8 mclk cycles between frames.
// Notes:   Link logic on sck, status and programming on mclk.
//
// Behaviour
// - Status write refused when pin enable set and protect pin low.
// - Array and status writes need the write latch set first.
// - Block-protected array bytes are never programmed.
// - Latch set only by an exactly 8-bit set-latch frame.
// - Clear-latch instruction drops the write latch.
// - Write frame: opcode, 16 address bits, data; top address bit ignored.
// - Programming starts only at the deselect ending a valid frame.
// - While programming, only status read is answered.
// - Busy flag high for the whole internal write cycle.
// - Up to 64 bytes per frame, only in-page bits increment.
// - Loading past page end wraps to the first byte of that page.
// - End of any internal write clears the write latch.
// - Status read while programming returns all ones.
// - Id-page select routes access to the 64-byte page by bits 5..0.
// - Id-page write refused if fully protected, locked or protected byte.
// - Status write changes bits 2,3,4,6,7 only.
// - Protect pin falling during a status write frame aborts it.
// - Protect pin ignored while pin enable is clear.
// - Reads auto-increment and wrap until deselect.
// - Status shifted out right after the status-read opcode.
// - Hold pauses the link and floats the output.
// - Only the six opcodes are decoded, others ignored.
// - Status byte order: enable, id select, 0, lock, bp hi, bp lo, latch, busy.
// - Block protect: none, top quarter, top half, whole array.
// - Id-page select clears after each read or write.
`include "ee_map.svh"
`default_nettype none
module ee_spi_core
   import ee_pkg::*;
#(
   parameter int TWC_CYC = `TWC_CYC
)
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       hold_n,
   input  wire logic       wp_n,
   output logic            so,
   output logic            so_oe,
   output logic [7:0]      status
);

   lnk_t       l_reg;
   lnk_t       l_next;
   frm_t       f_reg;
   frm_t       f_next;
   out_t       o_reg;
   out_t       o_next;
   mst_t       m_reg;
   mst_t       m_next;
   logic [7:0] mem  [0:32767];
   logic [7:0] idp  [0:63];
   logic [7:0] pbuf [0:63];
   logic [7:0] sr_byte;
   logic [5:0] b;
   logic [7:0] opn;
   logic [15:0] an;
   logic [14:0] ra;
   logic [7:0] rbyte;
   logic [7:0] bdat;
   logic       ld;
   logic       bwe;
   logic       cs_rise;
   logic       srblk;
   logic       we;
   logic [14:0] wa;

   // Protected range for an address under a block protect code
   function automatic logic prot(input logic [1:0] bp, input logic [14:0] a);
      logic p;
      p = 1'b0;
      case (bp)
         `BP_QUARTER: p = (a[14:13] == 2'b11);
         `BP_HALF:    p = a[14];
         `BP_ALL:     p = 1'b1;
         default:     p = 1'b0;
      endcase
      return p;
   endfunction : prot

   // Status byte as seen by the host
   assign sr_byte = {m_reg.protect_pin_enable, m_reg.id_page_select, 1'b0, m_reg.id_page_lock,
                     m_reg.bp, m_reg.write_enable_latch, m_reg.busy};

   // Link side: shift in, decode, load page, shift out
   always_comb
   begin
      b     = f_reg.bcnt;
      opn   = (b < `BITS_OP) ? {l_reg.op[6:0], si} : l_reg.op;
      an    = {l_reg.addr[14:0], si};
      ra    = (b == `LAST_HDR) ? an[14:0] : l_reg.rdp;
      rbyte = l_reg.ss2[`SR_IPL] ? idp[ra[5:0]] : mem[ra];
      bdat  = {l_reg.dsh[6:0], si};
      ld    = hold_n && (b[2:0] == 3'h7) &&
              ((opn == `OP_STATUS_RD && b >= `LAST_OP) ||
               (opn == `OP_READ && b >= `LAST_HDR));
      bwe   = hold_n && (l_reg.op == `OP_WRITE) && (b >= `LAST_DAT) &&
              (b[2:0] == 3'h7) && !l_reg.ss2[`SR_BUSY];
      f_next = f_reg;
      l_next = l_reg;
      if (hold_n)
      begin
         f_next.bcnt  = (b == `BITS_WRAP) ? `BITS_DAT : b + 6'h01;
         l_next.ss1   = sr_byte;
         l_next.ss2   = l_reg.ss1;
         l_next.nbits = f_next.bcnt;
         if (b == 6'h00)
         begin
            l_next.mask = '0;
            l_next.rden = 1'b0;
         end
         if (b < `BITS_OP)
         begin
            l_next.op = opn;
         end
         else
         begin
            l_next.dsh = bdat;
            if (b < `BITS_DAT - 6'h08)
            begin
               l_next.addr = an;
            end
         end
         if (b == `LAST_HDR)
         begin
            l_next.pg = an[5:0];
         end
         if (bwe)
         begin
            l_next.mask[l_reg.pg] = 1'b1;
            l_next.pg             = l_reg.pg + 6'h01;
         end
         if (ld && opn == `OP_STATUS_RD)
         begin
            l_next.tx   = l_reg.ss2[`SR_BUSY] ? `BUSY_BYTE : l_reg.ss2;
            l_next.rden = 1'b1;
         end
         else if (ld && !l_reg.ss2[`SR_BUSY])
         begin
            l_next.tx   = rbyte;
            l_next.rdp  = ra + 15'h0001;
            l_next.rden = 1'b1;
         end
         else if (ld)
         begin
            l_next.rden = 1'b0;
         end
         else
         begin
            l_next.tx = {l_reg.tx[6:0], 1'b0};
         end
      end
   end

   // Link state that outlives the frame
   always_ff @(posedge sck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         l_reg <= '0;
      end
      else
      begin
         l_reg <= l_next;
      end
   end

   // Frame bit counter, cleared while deselected
   always_ff @(posedge sck or negedge rst_n or posedge cs_n)
   begin
      if (!rst_n || cs_n)
      begin
         f_reg <= '0;
      end
      else
      begin
         f_reg <= f_next;
      end
   end

   // Page buffer, filled in-page with wrap
   always_ff @(posedge sck)
   begin
      if (bwe)
      begin
         pbuf[l_reg.pg] <= bdat;
      end
   end

   // Output drive on the falling edge
   always_comb
   begin
      o_next.so = l_reg.tx[7];
      o_next.oe = hold_n && l_reg.rden;
   end

   always_ff @(negedge sck or negedge rst_n or posedge cs_n)
   begin
      if (!rst_n || cs_n)
      begin
         o_reg <= '0;
      end
      else
      begin
         o_reg <= o_next;
      end
   end

   // System side: pin filters, command commit, programming sequencer
   always_comb
   begin
      m_next     = m_reg;
      m_next.cs1 = cs_n;
      m_next.cs2 = m_reg.cs1;
      m_next.cs3 = m_reg.cs2;
      m_next.wp1 = wp_n;
      m_next.wp2 = m_reg.wp1;
      m_next.wp3 = m_reg.wp2;
      if (m_reg.cs2 == m_reg.cs3)
      begin
         m_next.csq = m_reg.cs3;
      end
      if (m_reg.wp2 == m_reg.wp3)
      begin
         m_next.wpq = m_reg.wp3;
      end
      cs_rise = !m_reg.csq && m_next.csq;
      // Protect pin falling inside a frame
      if (m_reg.csq && !m_next.csq)
      begin
         m_next.wpfell = 1'b0;
      end
      else if (!m_reg.csq && m_reg.wpq && !m_next.wpq)
      begin
         m_next.wpfell = 1'b1;
      end
      srblk = m_reg.protect_pin_enable && (!m_next.wpq || m_next.wpfell);
      case (m_reg.st)
         ST_IDLE:
         begin
            if (cs_rise && !m_reg.busy)
            begin
               if (l_reg.op == `OP_SET_WL && l_reg.nbits == `BITS_OP)
               begin
                  m_next.write_enable_latch = 1'b1;
               end
               else if (l_reg.op == `OP_CLR_WL && l_reg.nbits >= `BITS_OP)
               begin
                  m_next.write_enable_latch = 1'b0;
               end
               else if (l_reg.op == `OP_STATUS_WR && l_reg.nbits == `BITS_SR &&
                        m_reg.write_enable_latch && !srblk)
               begin
                  m_next.protect_pin_enable = l_reg.dsh[`SR_PROTECT_PIN_ENABLE];
                  m_next.bp   = l_reg.dsh[`SR_BP_HI:`SR_BP_LO];
                  if (!(l_reg.dsh[`SR_IPL] && l_reg.dsh[`SR_LIP]))
                  begin
                     m_next.id_page_select = l_reg.dsh[`SR_IPL];
                     m_next.id_page_lock = l_reg.dsh[`SR_LIP];
                  end
                  m_next.busy = 1'b1;
                  m_next.st   = ST_WAIT;
                  m_next.cnt  = 24'(TWC_CYC - 1);
               end
               else if (l_reg.op == `OP_WRITE)
               begin
                  m_next.id_page_select = 1'b0;
                  if (l_reg.nbits >= `BITS_DAT && l_reg.nbits[2:0] == 3'h0 &&
                      m_reg.write_enable_latch &&
                      !(m_reg.id_page_select && (m_reg.id_page_lock || m_reg.bp == `BP_ALL)))
                  begin
                     m_next.busy  = 1'b1;
                     m_next.st    = ST_PROG;
                     m_next.idx   = 6'h00;
                     m_next.tip   = m_reg.id_page_select;
                     m_next.pga   = l_reg.addr[14:6];
                     m_next.wmask = l_reg.mask;
                  end
               end
               else if (l_reg.op == `OP_READ)
               begin
                  m_next.id_page_select = 1'b0;
               end
            end
         end
         ST_PROG:
         begin
            m_next.idx = m_reg.idx + 6'h01;
            if (m_reg.idx == 6'h3f)
            begin
               m_next.st  = ST_WAIT;
               m_next.cnt = 24'(TWC_CYC - 1);
            end
         end
         ST_WAIT:
         begin
            if (m_reg.cnt == 24'h000000)
            begin
               m_next.st   = ST_IDLE;
               m_next.busy = 1'b0;
               m_next.write_enable_latch  = 1'b0;
            end
            else
            begin
               m_next.cnt = m_reg.cnt - 24'h000001;
            end
         end
         default:
         begin
            m_next.st = ST_IDLE;
         end
      endcase
      // Commit one loaded page byte per cycle
      wa = m_reg.tip ? {9'h000, m_reg.idx} : {m_reg.pga, m_reg.idx};
      we = (m_reg.st == ST_PROG) && m_reg.wmask[m_reg.idx] &&
           !prot(m_reg.bp, wa);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         m_reg      <= '0;
         m_reg.cs1  <= 1'b1;
         m_reg.cs2  <= 1'b1;
         m_reg.cs3  <= 1'b1;
         m_reg.csq  <= 1'b1;
         m_reg.wp1  <= 1'b1;
         m_reg.wp2  <= 1'b1;
         m_reg.wp3  <= 1'b1;
         m_reg.wpq  <= 1'b1;
         m_reg.protect_pin_enable <= `PROTECT_PIN_ENABLE_RST;
         m_reg.id_page_lock  <= `LIP_RST;
         m_reg.bp   <= `BP_RST;
      end
      else
      begin
         m_reg <= m_next;
      end
   end

   // Array and id page write port
   always_ff @(posedge mclk)
   begin
      if (we && !m_reg.tip)
      begin
         mem[wa] <= pbuf[m_reg.idx];
      end
      if (we && m_reg.tip)
      begin
         idp[m_reg.idx] <= pbuf[m_reg.idx];
      end
   end

   assign so     = o_reg.so;
   assign so_oe  = o_reg.oe;
   assign status = sr_byte;

   // Checks on the system side
   a_wel_set_cause: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(m_reg.write_enable_latch) |-> $past(cs_rise && l_reg.op == `OP_SET_WL &&
                                 l_reg.nbits == `BITS_OP))
      else $error("write latch set without a set-latch frame");
   a_wel_clear_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && !m_reg.busy && l_reg.op == `OP_CLR_WL |=> !m_reg.write_enable_latch)
      else $error("clear-latch did not clear the latch");
   a_no_wel_write: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && !m_reg.write_enable_latch |=> !m_reg.busy)
      else $error("write started with latch clear");
   a_sr_wp_block: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && !m_reg.busy && srblk && l_reg.op == `OP_STATUS_WR |=>
      $stable(m_reg.bp) && !m_reg.busy)
      else $error("status write passed the protect pin");
   a_busy_start: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(m_reg.busy) |-> $past(cs_rise))
      else $error("busy rose without a deselect");
   a_busy_end_wel: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(m_reg.busy) |-> !m_reg.write_enable_latch)
      else $error("latch still set after write cycle");
   a_busy_steady: assert property (@(posedge mclk) disable iff (!rst_n)
      m_reg.st == ST_WAIT && m_reg.cnt != 24'h000000 |=> m_reg.busy &&
      $stable({m_reg.protect_pin_enable, m_reg.id_page_lock, m_reg.bp}))
      else $error("busy dropped or status moved mid cycle");
   a_full_protect: assert property (@(posedge mclk) disable iff (!rst_n)
      m_reg.st == ST_PROG && m_reg.bp == `BP_ALL |-> !we)
      else $error("protected byte programmed");
   a_ipl_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && !m_reg.busy && l_reg.op == `OP_READ |=> !m_reg.id_page_select)
      else $error("id page select kept after read");
   a_prog_run: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(m_reg.st == ST_PROG) |-> (m_reg.st == ST_PROG)[*8])
      else $error("page commit cut short");

   // Checks on the link side
   a_hold_float: assert property (@(negedge sck) disable iff (!rst_n || cs_n)
      !hold_n |=> !o_reg.oe)
      else $error("output driven during hold");
   a_busy_status: assert property (@(posedge sck) disable iff (!rst_n)
      ld && opn == `OP_STATUS_RD && l_reg.ss2[`SR_BUSY] |=> l_reg.tx == `BUSY_BYTE)
      else $error("status read while busy not all ones");

   c_page_write: cover property (@(posedge mclk) disable iff (!rst_n)
      $rose(m_reg.st == ST_PROG));
   c_sr_write: cover property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && l_reg.op == `OP_STATUS_WR && m_reg.write_enable_latch && !srblk);
   c_wp_abort: cover property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && m_reg.wpfell && m_reg.protect_pin_enable);
   c_busy_poll: cover property (@(posedge sck) disable iff (!rst_n)
      ld && opn == `OP_STATUS_RD && l_reg.ss2[`SR_BUSY]);

endmodule : ee_spi_core
`default_nettype wire

// [pkg/ee_map.svh]
// Purpose: Offsets, opcodes, field positions, reset values and timing.
// Assumes: Included by bare name from the package and the core.
// Notes:   Definitions only.
`ifndef EE_MAP_SVH
`define EE_MAP_SVH
// Instruction opcodes
`define OP_SET_WL    8'h06
`define OP_CLR_WL    8'h04
`define OP_STATUS_RD 8'h05
`define OP_STATUS_WR 8'h01
`define OP_READ      8'h03
`define OP_WRITE     8'h02
// Status byte bit positions
`define SR_PROTECT_PIN_ENABLE      7
`define SR_IPL       6
`define SR_LIP       4
`define SR_BP_HI     3
`define SR_BP_LO     2
`define SR_WEL       1
`define SR_BUSY      0
// Reset values of the kept status bits
`define PROTECT_PIN_ENABLE_RST     1'b0
`define LIP_RST      1'b0
`define BP_RST       2'b00
// Status read answer while programming
`define BUSY_BYTE    8'hff
// Frame bit counts
`define BITS_OP      6'h08
`define BITS_SR      6'h10
`define LAST_OP      6'h07
`define LAST_HDR     6'h17
`define BITS_DAT     6'h20
`define LAST_DAT     6'h1f
`define BITS_WRAP    6'h27
// Block protect codes
`define BP_NONE      2'b00
`define BP_QUARTER   2'b01
`define BP_HALF      2'b10
`define BP_ALL       2'b11
// Internal write time and clock period
`define TWC_NS       5000000
`define MCLK_NS      4
`define TWC_CYC      (`TWC_NS / `MCLK_NS)
`endif

// [pkg/ee_pkg.sv]
// Purpose: Types shared by the serial EEPROM core.
// Assumes: ee_map.svh on the include path.
// Notes:   Link state is three packed structs, system clock state is one.
`include "ee_map.svh"
`default_nettype none
package ee_pkg;
   // Programming sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PROG = 2'b01,
      ST_WAIT = 2'b10
   } wst_t;
   // Link domain, survives the end of a frame
   typedef struct packed {
      logic [7:0]  op;
      logic [15:0] addr;
      logic [7:0]  dsh;
      logic [7:0]  tx;
      logic [14:0] rdp;
      logic [5:0]  pg;
      logic [63:0] mask;
      logic [5:0]  nbits;
      logic        rden;
      logic [7:0]  ss1;
      logic [7:0]  ss2;
   } lnk_t;
   // Link domain, cleared by a deselect
   typedef struct packed {
      logic [5:0] bcnt;
   } frm_t;
   // Output stage on the falling clock edge
   typedef struct packed {
      logic so;
      logic oe;
   } out_t;
   // System clock domain
   typedef struct packed {
      logic        cs1;
      logic        cs2;
      logic        cs3;
      logic        csq;
      logic        wp1;
      logic        wp2;
      logic        wp3;
      logic        wpq;
      logic        wpfell;
      logic        protect_pin_enable;
      logic        id_page_select;
      logic        id_page_lock;
      logic [1:0]  bp;
      logic        write_enable_latch;
      logic        busy;
      wst_t        st;
      logic [5:0]  idx;
      logic [23:0] cnt;
      logic        tip;
      logic [8:0]  pga;
      logic [63:0] wmask;
   } mst_t;
endpackage : ee_pkg
`default_nettype wire

// [testbench/spi_host.sv]
// Purpose: Host controller model for the serial link.
// Assumes: Mode 0, 32 ns serial clock, clock low between frames.
// Notes:   Data line keeps changing while deselected.
`default_nettype none
module spi_host
(
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle levels
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end
   // Select falls with the clock low
   task automatic start();
      cs_n = 1'b0;
      #16;
   endtask : start
   // n bits MSB first, so captured on rising edges
   task automatic xb(input logic [7:0] b, input int n, output logic [7:0] q);
      q = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         si = b[i];
         #16;
         sck = 1'b1;
         q = {q[6:0], so};
         #16;
         sck = 1'b0;
      end
   endtask : xb
   // Deselect, then an idle gap of 12 mclk cycles
   task automatic stop();
      #16;
      cs_n = 1'b1;
      si = ~si;
      #48;
   endtask : stop
   // Pause with the clock low, one ignored clock, resume
   task automatic pause(output logic oe);
      hold_n = 1'b0;
      si = ~si;
      #16;
      sck = 1'b1;
      #16;
      sck = 1'b0;
      #16;
      oe = so_oe;
      hold_n = 1'b1;
      #16;
   endtask : pause
endmodule : spi_host
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the serial EEPROM core.
// Assumes: Host model drives the link; wp_n driven after mclk edges.
// Notes:   Shortened write time; byte model keyed by address.
`include "ee_map.svh"
`default_nettype none
module testbench
   import ee_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TWC = 600;
   logic       mclk, rst_n, sck, cs_n, si, hold_n, wp_n, so, so_oe, oe;
   logic [7:0] status, r, v;
   logic [7:0] mem [int];
   logic [15:0] eg [5] = '{16'h3fff, 16'h4000, 16'h5fff, 16'h6000, 16'h7fff};
   logic [7:0]  bad [3] = '{8'h07, 8'h86, 8'hff};
   int         failures, check_count, sd;
   logic [15:0] a;
   int          n;

   ee_spi_core #(.TWC_CYC(TWC)) dut (.mclk(mclk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
      .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .status(status));
   spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

   // System clock
   always #2 mclk = ~mclk;

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Model key: page wrap on load, linear wrap on read; id page above array
   function automatic int key(input logic [15:0] a, input int i, input logic ip,
                              input logic pg);
      logic [14:0] s;
      s = pg ? {a[14:6], 6'(a[5:0] + i)} : 15'(a + i);
      return ip ? 32768 + int'(s[5:0]) : int'(s);
   endfunction : key

   function automatic logic prot(input logic [15:0] a, input int b);
      case (b)
         1: return a[14:0] >= 15'h6000;
         2: return a[14:0] >= 15'h4000;
         3: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : prot

   task automatic setwp(input logic lv);
      @(posedge mclk);
      #1 wp_n = lv;
   endtask : setwp

   task automatic cmd(input logic [7:0] op, input int nb);
      host.start();
      host.xb(op, 8, r);
      if (nb > 8) host.xb(8'h00, nb - 8, r);
      host.stop();
   endtask : cmd

   task automatic srd(output logic [7:0] q);
      host.start();
      host.xb(`OP_STATUS_RD, 8, r);
      host.xb(8'h00, 8, q);
      host.stop();
   endtask : srd

   task automatic hdr(input logic [7:0] op, input logic [15:0] a);
      host.start();
      host.xb(op, 8, r);
      host.xb(a[15:8], 8, r);
      host.xb(a[7:0], 8, r);
   endtask : hdr

   // Busy check, ignored write while busy, wait for the end of the cycle
   task automatic settle(input logic ok, input logic probe, input logic lat);
      int k;
      logic [7:0] q;
      chk("busy", {7'h00, status[0]}, {7'h00, ok});
      if (probe)
      begin
         hdr(`OP_WRITE, 16'h0000);
         host.xb(~mem[0], 8, r);
         host.stop();
      end
      if (ok)
      begin
         srd(q);
         chk("busy status", q, `BUSY_BYTE);
      end
      k = 0;
      while (status[0] !== 1'b0 && k < 1000)
      begin
         @(posedge mclk);
         k++;
      end
      if (k == 1000) failures++;
      chk("latch", {7'h00, status[1]}, {7'h00, lat});
   endtask : settle

   task automatic wr(input logic [15:0] a, input int nb, input logic ok, input logic en,
                     input logic ip);
      logic [7:0] d;
      logic       acc;
      // A latched, whole-byte array write runs a cycle even into protected blocks
      acc = ok || (en && nb > 0 && !ip);
      if (en) cmd(`OP_SET_WL, 8);
      hdr(`OP_WRITE, a);
      for (int i = 0; i < nb; i++)
      begin
         d = 8'($urandom);
         host.xb(d, 8, r);
         if (ok) mem[key(a, i, ip, 1'b1)] = d;
      end
      host.stop();
      settle(acc, acc, en & ~acc);
   endtask : wr

   task automatic rd(input logic [15:0] a, input int nb, input logic ip);
      hdr(`OP_READ, a);
      for (int i = 0; i < nb; i++)
      begin
         host.xb(8'h00, 8, r);
         if (mem.exists(key(a, i, ip, 1'b0)))
            chk("read", r, mem[key(a, i, ip, 1'b0)]);
      end
      host.stop();
   endtask : rd

   task automatic sw(input logic [7:0] d, input logic ok, input logic drop);
      cmd(`OP_SET_WL, 8);
      host.start();
      host.xb(`OP_STATUS_WR, 8, r);
      if (drop) setwp(1'b0);
      host.xb(d, 8, r);
      if (drop) setwp(1'b1);
      host.stop();
      settle(ok, 1'b0, ~ok);
   endtask : sw

   // Watchdog
   initial
   begin
      #380000;
      failures++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      mclk = 1'b0;
      rst_n = 1'b0;
      wp_n = 1'b1;
      failures = 0;
      check_count = 0;
      sd = $urandom(98);
      repeat (10) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge mclk);
      chk("reset", status, 8'h00);
      cmd(`OP_SET_WL, 9);
      chk("long set", status, 8'h00);
      foreach (bad[j])
      begin
         cmd(bad[j], 8);
         chk("unknown op", status, 8'h00);
      end
      cmd(`OP_SET_WL, 8);
      chk("set latch", status, 8'h02);
      cmd(`OP_CLR_WL, 8);
      chk("clear latch", status, 8'h00);
      wr(16'h0000, 1, 1'b1, 1'b1, 1'b0);
      wr(16'h0000, 1, 1'b0, 1'b0, 1'b0);
      wr(16'h0300, 0, 1'b0, 1'b1, 1'b0);
      wr(16'h807e, 66, 1'b1, 1'b1, 1'b0);
      rd(16'h0040, 64, 1'b0);
      // Pause in mid-read
      hdr(`OP_READ, 16'h007e);
      host.xb(8'h00, 8, r);
      chk("pre hold", r, mem[16'h007e]);
      host.pause(oe);
      chk("hold float", {7'h00, oe}, 8'h00);
      host.xb(8'h00, 8, r);
      chk("post hold", r, mem[16'h007f]);
      host.stop();
      // Block protection codes
      for (int b = 0; b < 4; b++)
      begin
         sw(8'(b << 2), 1'b1, 1'b0);
         chk("bp", status, 8'(b << 2));
         foreach (eg[j]) wr(eg[j], 1, !prot(eg[j], b), 1'b1, 1'b0);
      end
      sw(8'h00, 1'b1, 1'b0);
      foreach (eg[j]) rd(eg[j], 1, 1'b0);
      rd(16'hffff, 2, 1'b0);
      // Status write field mask and pin protection
      sw(8'hab, 1'b1, 1'b0);
      srd(v);
      chk("status mask", v, 8'h88);
      setwp(1'b0);
      sw(8'h00, 1'b0, 1'b0);
      chk("pin protect", status, 8'h8a);
      setwp(1'b1);
      sw(8'h00, 1'b0, 1'b1);
      sw(8'h00, 1'b1, 1'b0);
      setwp(1'b0);
      sw(8'h04, 1'b1, 1'b0);
      chk("pin ignored", status, 8'h04);
      sw(8'h00, 1'b1, 1'b0);
      setwp(1'b1);
      // Identification page
      sw(8'h40, 1'b1, 1'b0);
      chk("id select", status, 8'h40);
      wr(16'hffc5, 3, 1'b1, 1'b1, 1'b1);
      chk("id clear", status, 8'h00);
      sw(8'h40, 1'b1, 1'b0);
      rd(16'h3fc5, 3, 1'b1);
      sw(8'h0c, 1'b1, 1'b0);
      sw(8'h4c, 1'b1, 1'b0);
      wr(16'h0010, 1, 1'b0, 1'b1, 1'b1);
      sw(8'h00, 1'b1, 1'b0);
      // Random page writes read back
      repeat (5)
      begin
         a = 16'($urandom);
         n = $urandom_range(8, 1);
         wr(a, n, 1'b1, 1'b1, 1'b0);
         rd(a, n, 1'b0);
      end
      rd(16'h0000, 1, 1'b0);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
